// ===== src/option_cfg_pkg.sv
// Constants, field layouts and carrier types for the option byte decoder.
// Assumes one system clock domain shared with the option storage port.
package option_cfg_pkg;

    localparam int          NUM_OPT_BYTES = 8;
    localparam int          OPT_IDX_W     = 3;

    // Option byte slots in storage order.
    localparam logic [2:0]  IDX_READOUT    = 3'h0;
    localparam logic [2:0]  IDX_BOOT_AREA  = 3'h1;
    localparam logic [2:0]  IDX_PIN_REMAP  = 3'h2;
    localparam logic [2:0]  IDX_WDG_LOWCLK = 3'h3;
    localparam logic [2:0]  IDX_CLK_WAKEUP = 3'h4;
    localparam logic [2:0]  IDX_SETTLE     = 3'h5;
    localparam logic [2:0]  IDX_SPARE      = 3'h6;
    localparam logic [2:0]  IDX_FLASH_WAIT = 3'h7;
    localparam logic [2:0]  IDX_LAST       = 3'h7;

    localparam logic [7:0]  READOUT_ENABLE_CODE = 8'hAA;
    localparam logic [7:0]  BOOT_NONE_CODE      = 8'h00;
    localparam logic [7:0]  BOOT_FIRST_CODE     = 8'h01;
    localparam logic [7:0]  BOOT_FIRST_LAST_PG  = 8'h01;
    localparam logic [7:0]  BOOT_RESERVED_CODE  = 8'hFF;
    localparam logic [7:0]  BOOT_PAGE_STEP      = 8'h01;

    // Bit positions inside the remap byte.
    localparam int REMAP_BIT7 = 7;
    localparam int REMAP_BIT6 = 6;
    localparam int REMAP_BIT5 = 5;
    localparam int REMAP_BIT4 = 4;
    localparam int REMAP_BIT3 = 3;
    localparam int REMAP_BIT2 = 2;
    localparam int REMAP_BIT1 = 1;
    localparam int REMAP_BIT0 = 0;

    // Bit positions inside the watchdog, clock and wait bytes.
    localparam int LOW_SPEED_ALLOW_BIT = 3;
    localparam int INDEP_WDG_HW_BIT    = 2;
    localparam int WINDOW_WDG_HW_BIT   = 1;
    localparam int WINDOW_WDG_HALT_BIT = 0;
    localparam int EXT_CLOCK_BIT       = 3;
    localparam int WAKEUP_CLK_SEL_BIT  = 2;
    localparam int WAKEUP_DIV_HI       = 1;
    localparam int WAKEUP_DIV_LO       = 0;
    localparam int FLASH_WAIT_BIT      = 0;

    // Crystal settle codes and their waits in half oscillator cycles.
    localparam int          SETTLE_W          = 13;
    localparam logic [7:0]  SETTLE_CODE_2048  = 8'h00;
    localparam logic [7:0]  SETTLE_CODE_128   = 8'hB4;
    localparam logic [7:0]  SETTLE_CODE_8     = 8'hD2;
    localparam logic [7:0]  SETTLE_CODE_HALF  = 8'hE1;
    localparam logic [12:0] SETTLE_HALF_2048  = 13'h1000;
    localparam logic [12:0] SETTLE_HALF_128   = 13'h0100;
    localparam logic [12:0] SETTLE_HALF_8     = 13'h0010;
    localparam logic [12:0] SETTLE_HALF_HALF  = 13'h0001;

    // APB map.
    localparam int          APB_ADDR_W     = 8;
    localparam logic [7:0]  REG_OPT_BASE   = 8'h00;
    localparam logic [7:0]  REG_OPT_LAST   = 8'h1C;
    localparam logic [7:0]  REG_STATUS     = 8'h20;
    localparam logic [7:0]  REG_STAGED     = 8'h24;
    localparam int          WORD_LSB       = 2;
    localparam int          STAT_LOAD_DONE  = 0;
    localparam int          STAT_BOOT_RSVD  = 1;
    localparam int          STAT_SETTLE_ODD = 2;
    localparam int          STAT_READOUT    = 3;

    typedef enum logic [1:0] {
        PD0_TIMER3_CHANNEL2 = 2'b00,
        PD0_CLOCK_OUTPUT    = 2'b01,
        PD0_REMAP2_ALT      = 2'b10
    } pd0_func_e;

    typedef struct packed {
        logic      pd4_beeper_output;
        logic      pb54_i2c_lines;
        logic      pb30_timer1_group;
        logic      pd7_timer1_channel4;
        pd0_func_e pd0_func;
        logic      pa3d2_timer3_swap;
        logic      pd3_converter_trigger;
    } pin_mux_s;

    typedef struct packed {
        logic                readout_protection;
        logic                debug_write_allow;
        logic                boot_code_area_en;
        logic                boot_code_invalid;
        logic [7:0]          boot_last_page;
        pin_mux_s            pin_mux;
        logic                low_speed_cpu_clock_allow;
        logic                indep_watchdog_hw_start;
        logic                window_watchdog_hw_start;
        logic                window_watchdog_halt_reset;
        logic                external_clock_select;
        logic                wakeup_clock_select;
        logic [1:0]          wakeup_prescale_field;
        logic [SETTLE_W-1:0] crystal_settle_half;
        logic                crystal_settle_unlisted;
        logic                flash_wait_select;
    } cfg_s;

    // Safe values shown until the option bytes are in: protection on.
    localparam cfg_s CFG_RESET = '{readout_protection: 1'b1, default: '0};

    typedef enum logic [1:0] {
        LD_REQ  = 2'b00,
        LD_WAIT = 2'b01,
        LD_DONE = 2'b10
    } load_state_e;

endpackage : option_cfg_pkg

// ===== src/option_fetch_seq.sv
// Sequencer that reads every option byte from storage once after reset.
// Assumes storage answers each read with a one-cycle valid on this clock.
`timescale 1ns/100ps
`default_nettype none
module option_fetch_seq
    import option_cfg_pkg::*;
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 nvm_valid_i,
    output logic                      nvm_rd_o,
    output logic [OPT_IDX_W-1:0]      nvm_addr_o,
    output logic                      capture_o,
    output logic                      done_o
);

    load_state_e state_q;
    logic [OPT_IDX_W-1:0] idx_q;

    assign capture_o = (state_q == LD_WAIT) && nvm_valid_i;
    assign done_o    = (state_q == LD_DONE);
    assign nvm_addr_o = idx_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q  <= LD_REQ;
            idx_q    <= '0;
            nvm_rd_o <= 1'b0;
        end else begin
            nvm_rd_o <= 1'b0;
            unique case (state_q)
                LD_REQ: begin
                    nvm_rd_o <= 1'b1;
                    state_q  <= LD_WAIT;
                end
                LD_WAIT: begin
                    if (nvm_valid_i) begin
                        if (idx_q == IDX_LAST) begin
                            state_q <= LD_DONE;
                        end else begin
                            idx_q   <= idx_q + 1'b1;
                            state_q <= LD_REQ;
                        end
                    end
                end
                LD_DONE: begin
                    state_q <= LD_DONE;
                end
                default: begin
                    state_q <= LD_DONE;
                end
            endcase
        end
    end

endmodule : option_fetch_seq
`default_nettype wire

// ===== src/option_field_decode.sv
// Pure decode of the eight raw option bytes into the configuration carrier.
// Assumes the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
module option_field_decode
    import option_cfg_pkg::*;
(
    input  wire logic [NUM_OPT_BYTES-1:0][7:0] opt_i,
    output cfg_s                               cfg_o
);

    logic [7:0] boot_b;
    logic [7:0] remap_b;
    logic [7:0] wdg_b;
    logic [7:0] clk_b;

    assign boot_b  = opt_i[IDX_BOOT_AREA];
    assign remap_b = opt_i[IDX_PIN_REMAP];
    assign wdg_b   = opt_i[IDX_WDG_LOWCLK];
    assign clk_b   = opt_i[IDX_CLK_WAKEUP];

    always_comb begin
        cfg_o = '0;
        cfg_o.readout_protection = (opt_i[IDX_READOUT] == READOUT_ENABLE_CODE);
        cfg_o.debug_write_allow  = (opt_i[IDX_READOUT] != READOUT_ENABLE_CODE);
        // The reserved code protects nothing and is flagged instead.
        cfg_o.boot_code_invalid  = (boot_b == BOOT_RESERVED_CODE);
        cfg_o.boot_code_area_en  = (boot_b != BOOT_NONE_CODE)
                                 && (boot_b != BOOT_RESERVED_CODE);
        if (!cfg_o.boot_code_area_en) begin
            cfg_o.boot_last_page = '0;
        end else if (boot_b == BOOT_FIRST_CODE) begin
            cfg_o.boot_last_page = BOOT_FIRST_LAST_PG;
        end else begin
            cfg_o.boot_last_page = 8'(boot_b + BOOT_PAGE_STEP);
        end
        cfg_o.pin_mux.pd4_beeper_output     = remap_b[REMAP_BIT7];
        cfg_o.pin_mux.pb54_i2c_lines        = remap_b[REMAP_BIT6];
        cfg_o.pin_mux.pb30_timer1_group     = remap_b[REMAP_BIT5];
        cfg_o.pin_mux.pd7_timer1_channel4   = !remap_b[REMAP_BIT4];
        if (remap_b[REMAP_BIT2]) begin
            cfg_o.pin_mux.pd0_func = PD0_REMAP2_ALT;
        end else if (remap_b[REMAP_BIT3]) begin
            cfg_o.pin_mux.pd0_func = PD0_CLOCK_OUTPUT;
        end else begin
            cfg_o.pin_mux.pd0_func = PD0_TIMER3_CHANNEL2;
        end
        cfg_o.pin_mux.pa3d2_timer3_swap     = remap_b[REMAP_BIT1];
        cfg_o.pin_mux.pd3_converter_trigger = remap_b[REMAP_BIT0];
        cfg_o.low_speed_cpu_clock_allow  = wdg_b[LOW_SPEED_ALLOW_BIT];
        cfg_o.indep_watchdog_hw_start    = wdg_b[INDEP_WDG_HW_BIT];
        cfg_o.window_watchdog_hw_start   = wdg_b[WINDOW_WDG_HW_BIT];
        cfg_o.window_watchdog_halt_reset = wdg_b[WINDOW_WDG_HALT_BIT];
        cfg_o.external_clock_select      = clk_b[EXT_CLOCK_BIT];
        cfg_o.wakeup_clock_select        = clk_b[WAKEUP_CLK_SEL_BIT];
        cfg_o.wakeup_prescale_field      = clk_b[WAKEUP_DIV_HI:WAKEUP_DIV_LO];
        // Unlisted settle codes fall back to the longest wait, which is always safe.
        cfg_o.crystal_settle_unlisted = 1'b0;
        unique case (opt_i[IDX_SETTLE])
            SETTLE_CODE_128:  cfg_o.crystal_settle_half = SETTLE_HALF_128;
            SETTLE_CODE_8:    cfg_o.crystal_settle_half = SETTLE_HALF_8;
            SETTLE_CODE_HALF: cfg_o.crystal_settle_half = SETTLE_HALF_HALF;
            SETTLE_CODE_2048: cfg_o.crystal_settle_half = SETTLE_HALF_2048;
            default: begin
                cfg_o.crystal_settle_half     = SETTLE_HALF_2048;
                cfg_o.crystal_settle_unlisted = 1'b1;
            end
        endcase
        cfg_o.flash_wait_select = opt_i[IDX_FLASH_WAIT][FLASH_WAIT_BIT];
    end

endmodule : option_field_decode
`default_nettype wire

// ===== src/option_byte_config_decoder.sv
// Top of the option byte decoder: loads the option bytes after reset, holds
// the decoded configuration for clock, watchdog, pin-mux and flash logic,
// and gives software an APB view with a staging port for reprogramming.
// Assumes storage and APB master run on clk_sys_i.
//
// Functional notes
// - Code AA enables readout protection, blocks debug writes.
// - Boot code 00 protects nothing; FF is reserved.
// - Boot codes protect pages from 0 upward.
// - Remap bit 7 picks timer2 ch1 or beeper.
// - Remap bit 6 picks analog inputs or I2C.
// - Remap bit 5 picks analog inputs or timer1 group.
// - Remap bit 4 clear gives timer1 channel 4.
// - Remap bit 2 outranks bit 3 on pin D0.
// - Remap bit 1 swaps timer channels on A3/D2.
// - Remap bit 0 picks timer2 ch2 or converter trigger.
// - Low-speed clock as CPU clock only when allowed.
// - Independent watchdog hardware start bit.
// - Window watchdog hardware start bit.
// - Halt resets when enabled and window watchdog active.
// - Select crystal or single external clock input.
// - Wake-up clock: low-speed internal or prescaled external.
// - Prescale field names the external clock frequency.
// - Settle count code sets crystal ready wait.
// - Wait option adds one flash read wait state.
`timescale 1ns/100ps
`default_nettype none
module option_byte_config_decoder
    import option_cfg_pkg::*;
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [APB_ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    output logic                       nvm_rd_o,
    output logic      [OPT_IDX_W-1:0]  nvm_addr_o,
    input  wire logic [7:0]            nvm_data_i,
    input  wire logic                  nvm_valid_i,
    output logic                       prog_we_o,
    output logic      [OPT_IDX_W-1:0]  prog_addr_o,
    output logic      [7:0]            prog_data_o,
    input  wire logic                  halt_i,
    input  wire logic                  window_watchdog_active_i,
    output logic                       halt_reset_o,
    output cfg_s                       cfg_o,
    output logic                       cfg_valid_o
);

    logic [NUM_OPT_BYTES-1:0][7:0] opt_q;
    logic [NUM_OPT_BYTES-1:0]      staged_q;
    logic                          capture;
    logic                          load_done;
    logic                          load_done_q;
    logic [OPT_IDX_W-1:0]          fetch_addr;
    cfg_s                          cfg_d;
    logic                          halt_q;

    logic                          apb_access;
    logic                          apb_take;
    logic                          opt_hit;
    logic                          status_hit;
    logic                          staged_hit;
    logic                          addr_hit;
    logic [OPT_IDX_W-1:0]          word_idx;
    logic [31:0]                   rdata_d;

    option_fetch_seq u_fetch (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .nvm_valid_i (nvm_valid_i),
        .nvm_rd_o    (nvm_rd_o),
        .nvm_addr_o  (fetch_addr),
        .capture_o   (capture),
        .done_o      (load_done)
    );

    assign nvm_addr_o = fetch_addr;

    option_field_decode u_decode (
        .opt_i (opt_q),
        .cfg_o (cfg_d)
    );

    // Raw bytes are written only by the load sequence; software writes go
    // to the staging port instead so the running configuration never moves.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opt_q <= '0;
        end else if (capture) begin
            opt_q[fetch_addr] <= nvm_data_i;
        end
    end

    // The decoded set is registered once, on the cycle after the last byte.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_done_q <= 1'b0;
            cfg_o       <= CFG_RESET;
            cfg_valid_o <= 1'b0;
        end else begin
            load_done_q <= load_done;
            if (load_done && !load_done_q) begin
                cfg_o       <= cfg_d;
                cfg_valid_o <= 1'b1;
            end
        end
    end

    // Halt reset: one pulse when halt is entered with the window watchdog
    // running and the halt option set.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            halt_q       <= 1'b0;
            halt_reset_o <= 1'b0;
        end else begin
            halt_q       <= halt_i;
            halt_reset_o <= halt_i && !halt_q && window_watchdog_active_i
                         && cfg_o.window_watchdog_halt_reset && cfg_valid_o;
        end
    end

    // APB decode. Requests are held off with pready low until the options
    // are loaded, so reads never return the pre-load defaults.
    assign apb_access = psel_i && penable_i && !pready_o;
    assign apb_take   = apb_access && cfg_valid_o;
    assign word_idx   = paddr_i[WORD_LSB +: OPT_IDX_W];
    assign opt_hit    = (paddr_i >= REG_OPT_BASE) && (paddr_i <= REG_OPT_LAST)
                     && (paddr_i[WORD_LSB-1:0] == 2'h0);
    assign status_hit = (paddr_i == REG_STATUS);
    assign staged_hit = (paddr_i == REG_STAGED);
    assign addr_hit   = opt_hit || status_hit || staged_hit;

    always_comb begin
        rdata_d = '0;
        if (opt_hit) begin
            rdata_d[7:0] = opt_q[word_idx];
        end else if (status_hit) begin
            rdata_d[STAT_LOAD_DONE]  = cfg_valid_o;
            rdata_d[STAT_BOOT_RSVD]  = cfg_o.boot_code_invalid;
            rdata_d[STAT_SETTLE_ODD] = cfg_o.crystal_settle_unlisted;
            rdata_d[STAT_READOUT]    = cfg_o.readout_protection;
        end else if (staged_hit) begin
            rdata_d[NUM_OPT_BYTES-1:0] = staged_q;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end else begin
            pready_o  <= apb_take;
            pslverr_o <= apb_take && !addr_hit;
            if (apb_take && !pwrite_i) begin
                prdata_o <= rdata_d;
            end
        end
    end

    // A write to an option word is passed to storage as a program request
    // when the transfer completes; it takes effect only after the next reset.
    // The spare byte and the read-only words take no program request.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prog_we_o   <= 1'b0;
            prog_addr_o <= '0;
            prog_data_o <= '0;
            staged_q    <= '0;
        end else begin
            prog_we_o <= 1'b0;
            if (psel_i && penable_i && pready_o && pwrite_i && opt_hit
                && (word_idx != IDX_SPARE)) begin
                prog_we_o             <= 1'b1;
                prog_addr_o           <= word_idx;
                prog_data_o           <= pwdata_i[7:0];
                staged_q[word_idx]    <= 1'b1;
            end
        end
    end

endmodule : option_byte_config_decoder
`default_nettype wire

// ===== tb/option_nvm_model.sv
// Behavioural option storage: answers each read after a chosen latency.
// Assumes reads come one at a time on the system clock.
`timescale 1ns/100ps
`default_nettype none
module option_nvm_model
    import option_cfg_pkg::*;
(
    input  wire logic                          clk_sys_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          rd_i,
    input  wire logic [OPT_IDX_W-1:0]          addr_i,
    input  wire logic [NUM_OPT_BYTES-1:0][7:0] mem_i,
    input  wire logic [2:0]                    lat_i,
    output logic      [7:0]                    data_o,
    output logic                               valid_o
);
    logic [2:0]           cnt_q;
    logic [OPT_IDX_W-1:0] addr_q;
    logic                 tog_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q  <= 3'h0;
            addr_q <= '0;
            tog_q  <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
            if (rd_i) begin
                cnt_q  <= lat_i;
                addr_q <= addr_i;
            end else if (cnt_q != 3'h0) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end

    // Outside the answer cycle the data flips, so a late sample is caught.
    assign valid_o = (cnt_q == 3'h1);
    assign data_o  = valid_o ? mem_i[addr_q] : {8{tog_q}};
endmodule : option_nvm_model
`default_nettype wire

// ===== tb/option_byte_config_decoder_chk.sv
// Port checker for the option byte decoder.
// Assumes a single clock and the asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module option_cfg_chk
    import option_cfg_pkg::*;
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic [31:0]          prdata_o,
    input  wire logic                 pready_o,
    input  wire logic                 pslverr_o,
    input  wire logic                 nvm_rd_o,
    input  wire logic [OPT_IDX_W-1:0] nvm_addr_o,
    input  wire logic                 nvm_valid_i,
    input  wire logic                 halt_i,
    input  wire logic                 window_watchdog_active_i,
    input  wire logic                 halt_reset_o,
    input  wire cfg_s                 cfg_o,
    input  wire logic                 cfg_valid_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    ready_in_access_a: assert property (pready_o |-> psel_i && penable_i && cfg_valid_o)
        else $error("pready outside an access phase");
    cfg_frozen_a: assert property (cfg_valid_o |=> cfg_valid_o && $stable(cfg_o))
        else $error("configuration changed after load");
    debug_allow_a: assert property (cfg_valid_o |->
        cfg_o.debug_write_allow == !cfg_o.readout_protection)
        else $error("debug write allow wrong");
    boot_reserved_a: assert property (cfg_o.boot_code_invalid |->
        !cfg_o.boot_code_area_en && cfg_o.boot_last_page == 8'h00)
        else $error("reserved boot code protects pages");
    halt_fire_a: assert property ($rose(halt_i) && window_watchdog_active_i
        && cfg_o.window_watchdog_halt_reset |=> halt_reset_o)
        else $error("halt reset missing");
    halt_cause_a: assert property (halt_reset_o |->
        cfg_o.window_watchdog_halt_reset && window_watchdog_active_i ##1 !halt_reset_o)
        else $error("halt reset without cause");
    fetch_next_a: assert property (nvm_valid_i && nvm_addr_o != IDX_LAST && !cfg_valid_o
        |=> nvm_addr_o == 3'($past(nvm_addr_o) + 3'h1) ##1 nvm_rd_o)
        else $error("next option byte not fetched");
    load_done_a: assert property (nvm_valid_i && nvm_addr_o == IDX_LAST
        |-> ##[1:2] cfg_valid_o)
        else $error("load did not complete");
    error_zero_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("error response with data");

    cover property (halt_reset_o);
    cover property (pslverr_o);
    cover property ($rose(cfg_valid_o));
endmodule : option_cfg_chk

bind option_byte_config_decoder option_cfg_chk u_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .nvm_rd_o(nvm_rd_o), .nvm_addr_o(nvm_addr_o),
    .nvm_valid_i(nvm_valid_i), .halt_i(halt_i),
    .window_watchdog_active_i(window_watchdog_active_i),
    .halt_reset_o(halt_reset_o), .cfg_o(cfg_o), .cfg_valid_o(cfg_valid_o));
`default_nettype wire

// ===== tb/tb_option_byte_config_decoder.sv
// Self-checking bench: loads random option bytes, checks the decode,
// APB view, program requests and halt reset. Assumes storage model beside.
`timescale 1ns/100ps
`default_nettype none
module tb_option_byte_config_decoder;
    import option_cfg_pkg::*;
    logic clk_sys_i, rst_n_i, psel_i, penable_i, pwrite_i, err;
    logic [7:0] paddr_i, nvm_data_i;
    logic [31:0] pwdata_i, prdata_o, rd, wd;
    logic pready_o, pslverr_o, nvm_rd_o, nvm_valid_i, prog_we_o;
    logic [2:0] nvm_addr_o, prog_addr_o, lat, pa;
    logic [7:0] prog_data_o, pd;
    logic halt_i, win_wd_act, halt_reset_o, cfg_valid_o;
    logic [7:0][7:0] mem;
    cfg_s cfg_o, e;
    int fails, checked, prog_cnt, hr_cnt, pc, hc;
    localparam logic [7:0] BOOTS [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hFE, 8'hFF};
    localparam logic [7:0] SETTLES [5] = '{8'h00, 8'hB4, 8'hD2, 8'hE1, 8'h37};

    option_byte_config_decoder dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .nvm_rd_o(nvm_rd_o), .nvm_addr_o(nvm_addr_o),
        .nvm_data_i(nvm_data_i), .nvm_valid_i(nvm_valid_i), .prog_we_o(prog_we_o),
        .prog_addr_o(prog_addr_o), .prog_data_o(prog_data_o), .halt_i(halt_i),
        .window_watchdog_active_i(win_wd_act), .halt_reset_o(halt_reset_o),
        .cfg_o(cfg_o), .cfg_valid_o(cfg_valid_o));
    option_nvm_model u_nvm (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rd_i(nvm_rd_o),
        .addr_i(nvm_addr_o), .mem_i(mem), .lat_i(lat), .data_o(nvm_data_i),
        .valid_o(nvm_valid_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        if (prog_we_o === 1'b1) begin
            prog_cnt++;
            pa = prog_addr_o;
            pd = prog_data_o;
        end
        if (halt_reset_o === 1'b1) hr_cnt++;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results

    // Model of the decode, written independently of the design.
    function automatic cfg_s model(input logic [7:0][7:0] b);
        cfg_s c;
        logic [7:0] r;
        c = '0;
        r = b[2];
        c.readout_protection = (b[0] == 8'hAA);
        c.debug_write_allow = (b[0] != 8'hAA);
        c.boot_code_invalid = (b[1] == 8'hFF);
        c.boot_code_area_en = (b[1] != 8'h00) && (b[1] != 8'hFF);
        if (c.boot_code_area_en) c.boot_last_page = (b[1] == 8'h01) ? 8'h01 : b[1] + 8'h01;
        c.pin_mux = '{r[7], r[6], r[5], !r[4],
                      pd0_func_e'(r[2] ? 2'b10 : {1'b0, r[3]}), r[1], r[0]};
        {c.low_speed_cpu_clock_allow, c.indep_watchdog_hw_start,
         c.window_watchdog_hw_start, c.window_watchdog_halt_reset} = b[3][3:0];
        {c.external_clock_select, c.wakeup_clock_select, c.wakeup_prescale_field} = b[4][3:0];
        c.crystal_settle_half = (b[5] == 8'hB4) ? 13'h0100 : (b[5] == 8'hD2) ? 13'h0010 :
                                (b[5] == 8'hE1) ? 13'h0001 : 13'h1000;
        c.crystal_settle_unlisted = !(b[5] inside {8'h00, 8'hB4, 8'hD2, 8'hE1});
        c.flash_wait_select = b[7][0];
        return c;
    endfunction : model

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 200);
        if (n >= 200) fails++;
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic do_reset;
        int n;
        rst_n_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        check(cfg_o, CFG_RESET);
        rst_n_i <= 1'b1;
        n = 0;
        while (cfg_valid_o !== 1'b1 && n < 300) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 300) fails++;
    endtask : do_reset

    initial begin
        {rst_n_i, psel_i, penable_i, pwrite_i, halt_i, win_wd_act} = '0;
        {paddr_i, pwdata_i, mem, fails, checked, prog_cnt, hr_cnt} = '0;
        lat = 3'h1;
        void'($urandom(86));
        for (int it = 0; it < 12; it++) begin
            mem = {$urandom, $urandom};
            mem[1] = BOOTS[it % 6];
            mem[5] = SETTLES[it % 5];
            if (it == 0) mem[0] = 8'hAA;
            if (it == 1) mem[2][3:2] = 2'b11;
            if (it[1]) mem[7][0] = 1'b1;
            lat <= 3'($urandom_range(1, 4));
            do_reset;
            e = model(mem);
            check(cfg_o, e);
            apb(1'b0, 8'(it % 8 * 4), 32'h0);
            check({err, rd}, {1'b0, 24'h0, mem[it % 8]});
            apb(1'b0, 8'h20, 32'h0);
            check(rd, {28'h0, e.readout_protection, e.crystal_settle_unlisted,
                       e.boot_code_invalid, 1'b1});
            pc = prog_cnt;
            wd = $urandom;
            apb(1'b1, 8'h04, wd);
            apb(1'b1, 8'h18, ~wd);
            apb(1'b0, 8'h24, 32'h0);
            check({err, rd, 8'(prog_cnt - pc), pa, pd}, {1'b0, 32'h2, 8'h1, 3'h1, wd[7:0]});
            check(cfg_o, e);
            apb(1'b0, 8'h40, 32'h0);
            check({err, rd}, {1'b1, 32'h0});
            hc = hr_cnt;
            win_wd_act <= it[0];
            @(posedge clk_sys_i);
            halt_i <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            check(hr_cnt - hc, it[0] & mem[3][0]);
            halt_i <= 1'b0;
        end
        results;
    end

    initial begin
        #200_000;
        fails++;
        results;
    end
endmodule : tb_option_byte_config_decoder
`default_nettype wire
